// [core/fdc_config.sv]
// What this block does
// - Loop oscillator divided by five-bit ratio field, valid 1 to 31.
// - Ten-bit integer multiplier N, reset value 086h.
// - Sixteen-bit fraction K, reset C226h, used only in fractional mode.
// - Reference range bit: 0 high-frequency locking, 1 low-frequency.
// - Fractional enable bit: 0 integer mode, 1 fractional mode.
// - Two-bit reference select: master, DAC frame, ADC frame, slow.
// - Mono bit sums left and right and halves the result.
// - Rate bit: 0 gives 256 times fs, 1 gives 272 times fs.
// - Two-bit de-emphasis select: none, 32k, 44.1k, 48k.
// - Modulator fast clock bit runs modulator above 64 times fs.
// - Left invert bit inverts left channel data polarity.
// - Right invert bit inverts right channel data polarity.
// - New volumes stay inactive until an update strobe is written.
// - Volume code 1 is -71.625dB, 0.375dB per further step.
// - Code zero mutes; volume resets to C0h, which is 0 dB.
// - Right volume register at next address, same coding and strobe.
`timescale 1ns/1ps
`default_nettype none
`include "fdc_regs.svh"

module fdc_config
  import fdc_pkg::*;
#(
  parameter int SAMPLE_W = 16
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] wr_data,
  output logic [15:0] rd_data,
  output logic rd_valid,
  input wire logic signed [SAMPLE_W-1:0] left_in,
  input wire logic signed [SAMPLE_W-1:0] right_in,
  output logic signed [SAMPLE_W-1:0] left_out,
  output logic signed [SAMPLE_W-1:0] right_out,
  output logic [4:0] vco_output_ratio,
  output logic [9:0] loop_integer_multiplier,
  output logic [15:0] loop_fraction_multiplier,
  output logic reference_range_select,
  output logic fractional_mode_enable,
  output logic [1:0] loop_reference_select,
  output logic [8:0] oversample_ratio,
  output logic [1:0] deemphasis_select,
  output logic modulator_fast_clock,
  output logic left_channel_enable,
  output logic right_channel_enable,
  output logic [7:0] left_volume_code,
  output logic [7:0] right_volume_code,
  output logic left_mute,
  output logic right_mute
);

  // ------------------------------------------------------------
  // Stored fields
  // ------------------------------------------------------------
  logic [4:0] ratio_r;
  logic [9:0] mult_n_r;
  logic [15:0] frac_k_r;
  logic ref_range_r, frac_en_r, mono_r, osr_sel_r, sdm_fast_r;
  logic [1:0] ref_sel_r, deemphasis_select_r;
  logic linv_r, rinv_r, lena_r, rena_r;
  logic [7:0] lvol_pend_r, rvol_pend_r, lvol_live_r, rvol_live_r;
  fdc_vstate_t vstate_r, vstate_nxt;
  // Write strobes per register
  logic wr_ratio, wr_frac, wr_ref, wr_dac, wr_vl, wr_vr, vu_hit;
  assign wr_ratio = wr_en && (reg_addr == `FDC_ADDR_RATIO_N);
  assign wr_frac = wr_en && (reg_addr == `FDC_ADDR_FRAC_K);
  assign wr_ref = wr_en && (reg_addr == `FDC_ADDR_REF_SETUP);
  assign wr_dac = wr_en && (reg_addr == `FDC_ADDR_DAC_CTRL);
  assign wr_vl = wr_en && (reg_addr == `FDC_ADDR_VOL_L);
  assign wr_vr = wr_en && (reg_addr == `FDC_ADDR_VOL_R);
  assign vu_hit = (wr_vl || wr_vr) && wr_data[`FDC_VU_BIT];

  // ------------------------------------------------------------
  // Loop configuration registers
  // ------------------------------------------------------------
  // ratio and N
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ratio_r <= `FDC_RST_RATIO;
      mult_n_r <= `FDC_RST_N;
    end else if (wr_ratio) begin
      ratio_r <= wr_data[`FDC_RATIO_MSB:`FDC_RATIO_LSB];
      mult_n_r <= wr_data[`FDC_N_MSB:0];
    end
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      frac_k_r <= `FDC_RST_K;
    end else if (wr_frac) begin
      frac_k_r <= wr_data;
    end
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ref_range_r <= 1'b0;
      frac_en_r <= 1'b0;
      ref_sel_r <= FDC_REF_MCLK;
    end else if (wr_ref) begin
      ref_range_r <= wr_data[`FDC_REFRANGE_BIT];
      frac_en_r <= wr_data[`FDC_FRAC_BIT];
      ref_sel_r <= wr_data[`FDC_SRC_MSB:0];
    end
  end

  // ------------------------------------------------------------
  // DAC path control
  // ------------------------------------------------------------
  // control fields
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mono_r <= 1'b0;
      osr_sel_r <= 1'b0;
      deemphasis_select_r <= FDC_DEEMPHASIS_SELECT_NONE;
      sdm_fast_r <= 1'b0;
      linv_r <= 1'b0;
      rinv_r <= 1'b0;
    end else if (wr_dac) begin
      mono_r <= wr_data[`FDC_MONO_BIT];
      osr_sel_r <= wr_data[`FDC_OSR_BIT];
      deemphasis_select_r <= wr_data[`FDC_DEEMPHASIS_SELECT_MSB:`FDC_DEEMPHASIS_SELECT_LSB];
      sdm_fast_r <= wr_data[`FDC_SDM_BIT];
      linv_r <= wr_data[`FDC_LINV_BIT];
      rinv_r <= wr_data[`FDC_RINV_BIT];
    end
  end

  // ------------------------------------------------------------
  // Volume registers, pending and live copies
  // ------------------------------------------------------------
  // pending codes and enables per channel
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      lvol_pend_r <= `FDC_RST_VOL;
      rvol_pend_r <= `FDC_RST_VOL;
      lena_r <= 1'b0;
      rena_r <= 1'b0;
    end else begin
      if (wr_vl) begin
        lvol_pend_r <= wr_data[7:0];
        lena_r <= wr_data[`FDC_ENA_BIT];
      end
      if (wr_vr) begin
        rvol_pend_r <= wr_data[7:0];
        rena_r <= wr_data[`FDC_ENA_BIT];
      end
    end
  end

  // Apply one cycle late, so a strobe write also carries its own code
  always_comb begin
    case (vstate_r)
      FDC_VS_IDLE: vstate_nxt = vu_hit ? FDC_VS_APPLY : FDC_VS_IDLE;
      FDC_VS_APPLY: vstate_nxt = vu_hit ? FDC_VS_APPLY : FDC_VS_IDLE;
      default: vstate_nxt = FDC_VS_IDLE;
    endcase
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      vstate_r <= FDC_VS_IDLE;
    end else begin
      vstate_r <= vstate_nxt;
    end
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      lvol_live_r <= `FDC_RST_VOL;
      rvol_live_r <= `FDC_RST_VOL;
    end else if (vstate_r == FDC_VS_APPLY) begin
      lvol_live_r <= lvol_pend_r;
      rvol_live_r <= rvol_pend_r;
    end
  end

  // ------------------------------------------------------------
  // Register read-back
  // ------------------------------------------------------------
  function automatic logic [15:0] read_word(input logic [7:0] a);
    logic [15:0] w;
    w = 16'h0000;
    case (a)
      `FDC_ADDR_RATIO_N: begin
        w[`FDC_RATIO_MSB:`FDC_RATIO_LSB] = ratio_r;
        w[`FDC_N_MSB:0] = mult_n_r;
      end
      `FDC_ADDR_FRAC_K: w = frac_k_r;
      `FDC_ADDR_REF_SETUP: begin
        w[`FDC_REFRANGE_BIT] = ref_range_r;
        w[`FDC_FRAC_BIT] = frac_en_r;
        w[`FDC_SRC_MSB:0] = ref_sel_r;
      end
      `FDC_ADDR_DAC_CTRL: begin
        w[`FDC_MONO_BIT] = mono_r;
        w[`FDC_OSR_BIT] = osr_sel_r;
        w[`FDC_DEEMPHASIS_SELECT_MSB:`FDC_DEEMPHASIS_SELECT_LSB] = deemphasis_select_r;
        w[`FDC_SDM_BIT] = sdm_fast_r;
        w[`FDC_LINV_BIT] = linv_r;
        w[`FDC_RINV_BIT] = rinv_r;
      end
      `FDC_ADDR_VOL_L: begin
        w[`FDC_ENA_BIT] = lena_r;
        w[7:0] = lvol_pend_r;
      end
      `FDC_ADDR_VOL_R: begin
        w[`FDC_ENA_BIT] = rena_r;
        w[7:0] = rvol_pend_r;
      end
      default: w = 16'h0000;
    endcase
    return w;
  endfunction : read_word

  // Registered read; strobe bit always reads back zero
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rd_data <= 16'h0000;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      if (rd_en) begin
        rd_data <= read_word(reg_addr);
      end
    end
  end

  // ------------------------------------------------------------
  // Configuration outputs
  // ------------------------------------------------------------
  // Registered copies keep every output on a flop
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      vco_output_ratio <= `FDC_RST_RATIO;
      loop_integer_multiplier <= `FDC_RST_N;
      loop_fraction_multiplier <= 16'h0000;
      reference_range_select <= 1'b0;
      fractional_mode_enable <= 1'b0;
      loop_reference_select <= FDC_REF_MCLK;
      oversample_ratio <= `FDC_OSR_NORMAL;
      deemphasis_select <= FDC_DEEMPHASIS_SELECT_NONE;
      modulator_fast_clock <= 1'b0;
      left_channel_enable <= 1'b0;
      right_channel_enable <= 1'b0;
      left_volume_code <= `FDC_RST_VOL;
      right_volume_code <= `FDC_RST_VOL;
      left_mute <= 1'b0;
      right_mute <= 1'b0;
    end else begin
      vco_output_ratio <= ratio_r;
      loop_integer_multiplier <= mult_n_r;
      loop_fraction_multiplier <= frac_en_r ? frac_k_r : 16'h0000;
      reference_range_select <= ref_range_r;
      fractional_mode_enable <= frac_en_r;
      loop_reference_select <= ref_sel_r;
      oversample_ratio <= osr_sel_r ? `FDC_OSR_USB : `FDC_OSR_NORMAL;
      deemphasis_select <= deemphasis_select_r;
      modulator_fast_clock <= sdm_fast_r;
      left_channel_enable <= lena_r;
      right_channel_enable <= rena_r;
      // live code passed to gain stage
      left_volume_code <= lvol_live_r;
      right_volume_code <= rvol_live_r;
      left_mute <= (lvol_live_r == `FDC_MUTE_CODE);
      right_mute <= (rvol_live_r == `FDC_MUTE_CODE);
    end
  end

  // ------------------------------------------------------------
  // Sample datapath: mono mix and polarity
  // ------------------------------------------------------------
  logic signed [SAMPLE_W:0] mix_sum;
  logic signed [SAMPLE_W-1:0] pre_l, pre_r;
  // halve the sum; the extra bit avoids overflow
  assign mix_sum = (SAMPLE_W+1)'(left_in) + (SAMPLE_W+1)'(right_in);
  always_comb begin
    if (mono_r) begin
      pre_l = mix_sum[SAMPLE_W:1];
      pre_r = mix_sum[SAMPLE_W:1];
    end else begin
      pre_l = left_in;
      pre_r = right_in;
    end
  end

  // bitwise inversion; avoids the negate overflow at min
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      left_out <= '0;
      right_out <= '0;
    end else begin
      left_out <= linv_r ? ~pre_l : pre_l;
      right_out <= rinv_r ? ~pre_r : pre_r;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_hold_vol;
    @(posedge mclk) disable iff (reset)
    (wr_vl && !vu_hit && vstate_r == FDC_VS_IDLE && !$past(vu_hit))
      |=> $stable(lvol_live_r);
  endproperty
  a_hold_vol: assert property (p_hold_vol) else $error("vol moved");
  property p_apply_vol;
    @(posedge mclk) disable iff (reset)
    vu_hit |-> ##3 (left_volume_code == $past(lvol_pend_r, 2));
  endproperty
  a_apply_vol: assert property (p_apply_vol) else $error("no apply");
  property p_mute;
    @(posedge mclk) disable iff (reset)
    (lvol_live_r == `FDC_MUTE_CODE) |=> left_mute;
  endproperty
  a_mute: assert property (p_mute) else $error("zero not muted");
  property p_kmask;
    @(posedge mclk) disable iff (reset)
    !frac_en_r |=> (loop_fraction_multiplier == 16'h0000);
  endproperty
  a_kmask: assert property (p_kmask) else $error("K not masked");
  property p_osr;
    @(posedge mclk) disable iff (reset)
    osr_sel_r |=> (oversample_ratio == `FDC_OSR_USB);
  endproperty
  a_osr: assert property (p_osr) else $error("USB ratio wrong");
  property p_ratio;
    @(posedge mclk) disable iff (reset)
    wr_ratio ##1 !wr_ratio |=>
      (vco_output_ratio == $past(wr_data[15:11], 2));
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio not applied");
  property p_linv;
    @(posedge mclk) disable iff (reset)
    (linv_r && !mono_r) |=> (left_out == ~$past(left_in));
  endproperty
  a_linv: assert property (p_linv) else $error("left polarity");
  property p_rinv;
    @(posedge mclk) disable iff (reset)
    (!rinv_r && !mono_r) |=> (right_out == $past(right_in));
  endproperty
  a_rinv: assert property (p_rinv) else $error("right polarity");
  property p_unmapped;
    @(posedge mclk) disable iff (reset)
    (rd_en && reg_addr == 8'h2e) |=> (rd_data == 16'h0000);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("not zero");

endmodule : fdc_config
`default_nettype wire

// [core/fdc_regs.svh]
`ifndef FDC_REGS_SVH
`define FDC_REGS_SVH

// --------------------------------------------------------------
// Register addresses (8-bit register index)
// --------------------------------------------------------------
`define FDC_ADDR_RATIO_N   8'h2b
`define FDC_ADDR_FRAC_K    8'h2c
`define FDC_ADDR_REF_SETUP 8'h2d
`define FDC_ADDR_DAC_CTRL  8'h30
`define FDC_ADDR_VOL_L     8'h32
`define FDC_ADDR_VOL_R     8'h33

// --------------------------------------------------------------
// Field positions
// --------------------------------------------------------------
`define FDC_RATIO_MSB   15
`define FDC_RATIO_LSB   11
`define FDC_N_MSB       9
`define FDC_REFRANGE_BIT 7
`define FDC_FRAC_BIT    5
`define FDC_SRC_MSB     1
`define FDC_MONO_BIT    13
`define FDC_OSR_BIT     12
`define FDC_DEEMPHASIS_SELECT_MSB   5
`define FDC_DEEMPHASIS_SELECT_LSB   4
`define FDC_SDM_BIT     3
`define FDC_LINV_BIT    1
`define FDC_RINV_BIT    0
`define FDC_ENA_BIT     15
`define FDC_VU_BIT      8

// --------------------------------------------------------------
// Reset values and the mute code
// --------------------------------------------------------------
`define FDC_RST_RATIO   5'h0e
`define FDC_RST_N       10'h086
`define FDC_RST_K       16'hc226
`define FDC_RST_VOL     8'hc0
`define FDC_MUTE_CODE   8'h00

// Multipliers of the sample rate for the two rate modes
`define FDC_OSR_NORMAL  9'h100
`define FDC_OSR_USB     9'h110

`endif

// [core/fdc_pkg.sv]
`default_nettype none
package fdc_pkg;
  // Loop reference sources
  typedef enum logic [1:0] {
    FDC_REF_MCLK = 2'h0,
    FDC_REF_DAC_FRAME = 2'h1,
    FDC_REF_ADC_FRAME = 2'h2,
    FDC_REF_SLOW = 2'h3
  } fdc_ref_t;
  // De-emphasis settings
  typedef enum logic [1:0] {
    FDC_DEEMPHASIS_SELECT_NONE = 2'h0,
    FDC_DEEMPHASIS_SELECT_32K = 2'h1,
    FDC_DEEMPHASIS_SELECT_44K1 = 2'h2,
    FDC_DEEMPHASIS_SELECT_48K = 2'h3
  } fdc_deemphasis_select_t;
  // Volume update sequencer states
  typedef enum logic [1:0] {
    FDC_VS_IDLE = 2'b01,
    FDC_VS_APPLY = 2'b10
  } fdc_vstate_t;
endpackage : fdc_pkg
`default_nettype wire

// [verification/fdc_config_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fdc_regs.svh"

module fdc_config_tb;
  // ------------------------------------------------------------
  // Signals and expected register image
  // ------------------------------------------------------------
  logic mclk, reset, wr_en, rd_en, rd_valid;
  logic [7:0] reg_addr;
  logic [15:0] wr_data, rd_data;
  logic signed [15:0] left_in, right_in, left_out, right_out;
  logic [4:0] vco_output_ratio;
  logic [9:0] loop_integer_multiplier;
  logic [15:0] loop_fraction_multiplier;
  logic reference_range_select, fractional_mode_enable, modulator_fast_clock;
  logic [1:0] loop_reference_select, deemphasis_select;
  logic [8:0] oversample_ratio;
  logic left_channel_enable, right_channel_enable, left_mute, right_mute;
  logic [7:0] left_volume_code, right_volume_code, live_l, live_r;
  logic [15:0] shadow [6];
  logic [7:0] addrs [6] = '{`FDC_ADDR_RATIO_N, `FDC_ADDR_FRAC_K,
    `FDC_ADDR_REF_SETUP, `FDC_ADDR_DAC_CTRL, `FDC_ADDR_VOL_L,
    `FDC_ADDR_VOL_R};
  // Readable bits only; strobe bit 8 never reads back
  logic [15:0] masks [6] = '{16'hfbff, 16'hffff, 16'h00a3, 16'h303b,
    16'h80ff, 16'h80ff};
  int mismatches, checked;

  fdc_config #(.SAMPLE_W(16)) u_fdc_config (.mclk(mclk), .reset(reset),
    .wr_en(wr_en), .rd_en(rd_en), .reg_addr(reg_addr), .wr_data(wr_data),
    .rd_data(rd_data), .rd_valid(rd_valid), .left_in(left_in),
    .right_in(right_in), .left_out(left_out), .right_out(right_out),
    .vco_output_ratio(vco_output_ratio),
    .loop_integer_multiplier(loop_integer_multiplier),
    .loop_fraction_multiplier(loop_fraction_multiplier),
    .reference_range_select(reference_range_select),
    .fractional_mode_enable(fractional_mode_enable),
    .loop_reference_select(loop_reference_select),
    .oversample_ratio(oversample_ratio),
    .deemphasis_select(deemphasis_select),
    .modulator_fast_clock(modulator_fast_clock),
    .left_channel_enable(left_channel_enable),
    .right_channel_enable(right_channel_enable),
    .left_volume_code(left_volume_code),
    .right_volume_code(right_volume_code),
    .left_mute(left_mute), .right_mute(right_mute));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    if (mismatches == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    @(negedge mclk);
    wr_en = 1'b1;
    reg_addr = a;
    wr_data = d;
    @(negedge mclk);
    wr_en = 1'b0;
  endtask : reg_write

  // Bounded wait so a missing answer cannot hang the run
  task automatic read_check(input logic [7:0] a, input logic [15:0] exp);
    int n;
    @(negedge mclk);
    rd_en = 1'b1;
    reg_addr = a;
    @(negedge mclk);
    rd_en = 1'b0;
    n = 0;
    while (rd_valid !== 1'b1 && n < 4) begin
      @(negedge mclk);
      n++;
    end
    check(rd_valid, 1'b1);
    check(rd_data, exp);
    @(negedge mclk);
    check(rd_valid, 1'b0);
  endtask : read_check

  task automatic check_cfg();
    logic [15:0] a, c, d;
    a = shadow[0];
    c = shadow[2];
    d = shadow[3];
    check(vco_output_ratio, a[15:11]);
    check(loop_integer_multiplier, a[9:0]);
    check(loop_fraction_multiplier, c[5] ? shadow[1] : 16'h0000);
    check(reference_range_select, c[7]);
    check(fractional_mode_enable, c[5]);
    check(loop_reference_select, c[1:0]);
    check(oversample_ratio, d[12] ? `FDC_OSR_USB : `FDC_OSR_NORMAL);
    check(deemphasis_select, d[5:4]);
    check(modulator_fast_clock, d[3]);
    check(left_channel_enable, shadow[4][15]);
    check(right_channel_enable, shadow[5][15]);
  endtask : check_cfg

  task automatic check_vol();
    check(left_volume_code, live_l);
    check(right_volume_code, live_r);
    check(left_mute, live_l == 8'h00);
    check(right_mute, live_r == 8'h00);
  endtask : check_vol

  // Mono sum keeps the carry before halving
  function automatic logic [15:0] dp(input logic [15:0] a,
    input logic [15:0] b, input logic mono, input logic inv);
    logic [16:0] s;
    logic [15:0] v;
    s = {a[15], a} + {b[15], b};
    v = mono ? s[16:1] : a;
    return inv ? ~v : v;
  endfunction : dp

  // Corner values for the first rounds: field ends, every code
  function automatic logic [15:0] corner(input int i, input int r);
    logic [1:0] q;
    logic [7:0] v;
    q = r[1:0];
    v = (q == 0) ? 8'h00 : (q == 1) ? 8'h01 : (q == 2) ? 8'hff : 8'hc0;
    case (i)
      0: return {q[0] ? 5'd31 : 5'd1, 1'b0, q[1] ? 10'h3ff : 10'h000};
      1: return q[0] ? 16'hffff : 16'h0001;
      2: return {8'h00, q[0], 1'b0, q[1], 3'b000, q};
      3: return {2'b00, q[0], q[1], 6'h00, q, 1'b1, 1'b0, q[0], q[1]};
      4: return {q[0], 6'h00, 1'b0, v};
      default: return {q[1], 6'h00, 1'b0, ~v};
    endcase
  endfunction : corner

  // ------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Whole run is under a thousand cycles; allow ample margin
  initial begin
    #2000000;
    mismatches++;
    finish_test();
  end

  initial begin
    logic [15:0] d;
    int k;
    reset = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    reg_addr = 8'h00;
    wr_data = 16'h0000;
    left_in = 16'sh0000;
    right_in = 16'sh0000;
    mismatches = 0;
    checked = 0;
    void'($urandom(95506));
    repeat (20) @(negedge mclk);
    reset = 1'b0;
    shadow = '{16'h7086, 16'hc226, 16'h0000, 16'h0000, 16'h00c0, 16'h00c0};
    live_l = `FDC_RST_VOL;
    live_r = `FDC_RST_VOL;
    @(negedge mclk);
    check_cfg();
    check_vol();
    for (int i = 0; i < 6; i++) read_check(addrs[i], shadow[i]);
    read_check(8'h31, 16'h0000);
    read_check(8'h2e, 16'h0000);
    // loop enables sit outside this block; never written here
    for (int r = 0; r < 16; r++) begin
      // Writes without strobe keep the live volume
      for (int i = 0; i < 6; i++) begin
        d = (r < 4) ? corner(i, r) : 16'($urandom);
        if (i >= 4) d[8] = 1'b0;
        reg_write(addrs[i], d);
        shadow[i] = d & masks[i];
      end
      reg_write(8'h31, 16'($urandom));
      repeat (3) @(negedge mclk);
      check_cfg();
      check_vol();
      for (int i = 0; i < 6; i++) read_check(addrs[i], shadow[i]);
      // strobe from either side applies both
      k = (r % 2) ? 5 : 4;
      reg_write(addrs[k], shadow[k] | 16'h0100);
      live_l = shadow[4][7:0];
      live_r = shadow[5][7:0];
      repeat (4) @(negedge mclk);
      check_vol();
      for (int s = 0; s < 8; s++) begin
        left_in = (s == 0) ? 16'sh7fff : 16'($urandom);
        right_in = (s == 0) ? 16'sh7fff : 16'($urandom);
        @(negedge mclk);
        check(left_out, dp(left_in, right_in, shadow[3][13],
          shadow[3][1]));
        check(right_out, dp(right_in, left_in, shadow[3][13],
          shadow[3][0]));
      end
    end
    finish_test();
  end
endmodule : fdc_config_tb
`default_nettype wire
